// *** src/crpt_pkg.sv ***
// constants for the register pattern self-test sequencer
// assumes a register port with one-cycle read latency on the far side
package crpt_pkg;
	localparam logic [31:0] PAT_A        = 32'h5555_5555;
	localparam logic [31:0] PAT_B        = 32'hAAAA_AAAA;
	localparam int          N_CALLER     = 7;
	localparam int          N_CALLEE     = 9;
	localparam int          N_CTRL       = 8;
	localparam logic [3:0]  CTRL_FLOAT_IX = 4'h7;
	// general register numbers, caller-saved group then callee-saved group
	localparam logic [3:0]  GPR_LIST [16] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hE, 4'hF,
		4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
	// control register selectors: isp usp vector_table_base psw bpc backup_status_word fast_interrupt_vector float_status_word
	localparam logic [2:0]  CTRL_SEL [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	// writable-bit masks; fixed bits are forced off in substitute patterns
	localparam logic [31:0] CTRL_MASK [8] = '{32'hFFFF_FFFC, 32'hFFFF_FFFC, 32'hFFFF_FFFC,
		32'h0013_000F, 32'hFFFF_FFFE, 32'h0013_000F, 32'hFFFF_FFFC, 32'h7C00_7CFF};
	localparam logic [31:0] PSW_ALT_MASK = 32'h0013_000F;
	localparam logic [31:0] RST_DATA     = 32'h0000_0000;
	typedef enum logic [3:0] {
		CRPT_IDLE, CRPT_WR_A, CRPT_WR_B, CRPT_RD_A, CRPT_RD_B, CRPT_CAP, CRPT_CHK,
		CRPT_CWR, CRPT_CRD, CRPT_CWT, CRPT_CCHK, CRPT_DONE, CRPT_FAULT
	} crpt_state_t;
endpackage : crpt_pkg

// *** src/crpt_sequencer.sv ***
// register pattern self-test sequencer: gpr pairs then control registers
// assumes the register file answers a read on the cycle after rd_en
// Notes on behaviour
// - first group two at a time
// - second group tests r0 and two at a time
// - each pair loaded with 0x55555555, read back, values must match
// - then pair loaded with 0xAAAAAAAA, read back, must match again
// - control test covers eight control registers stack to float status, seven (no float status) without HAS_FPU
// - each control register written, read, compared for both patterns
// - fixed bits handled by masked substitute patterns the register can hold
// - control test runs only after the general registers passed, or at once when RUN_CALLER and RUN_CALLEE are both off
// - any mismatch goes to common fault path, no result code
// - variant option selects PSW_ALT_MASK for both status words, equal to their default mask
`timescale 1ns/1ns
`default_nettype none
module crpt_sequencer #(
	parameter bit HAS_FPU     = 1'b1,
	parameter bit ALT_PSW     = 1'b0,
	parameter bit RUN_CALLER  = 1'b1,
	parameter bit RUN_CALLEE  = 1'b1,
	parameter bit RUN_CONTROL = 1'b1
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// control
	input  wire logic        start,
	output logic             busy,
	output logic             done,
	output logic             fault,
	// general register port
	output logic             gpr_we,
	output logic             gpr_re,
	output logic [3:0]       gpr_addr,
	output logic [31:0]      gpr_wdata,
	input  wire logic [31:0] gpr_rdata,
	// control register port
	output logic             ctl_we,
	output logic             ctl_re,
	output logic [2:0]       ctl_sel,
	output logic [31:0]      ctl_wdata,
	input  wire logic [31:0] ctl_rdata
);
	localparam int N_GPR = crpt_pkg::N_CALLER + crpt_pkg::N_CALLEE;

	function automatic logic [31:0] ctl_mask(input logic [3:0] ix);
		logic [31:0] m;
		m = crpt_pkg::CTRL_MASK[ix[2:0]];
		if (ALT_PSW && (ix == 4'h3 || ix == 4'h5))
			m = crpt_pkg::PSW_ALT_MASK;
		return m;
	endfunction : ctl_mask

	crpt_pkg::crpt_state_t st_r, st_nxt;
	logic [4:0]  ix_r, ix_nxt;
	logic        pat_r, pat_nxt;
	logic [31:0] first_r, first_nxt;
	logic        busy_nxt, done_nxt, fault_nxt;
	logic        gwe_nxt, gre_nxt, cwe_nxt, cre_nxt;
	logic [3:0]  gad_nxt;
	logic [2:0]  csel_nxt;
	logic [31:0] gwd_nxt, cwd_nxt;
	logic [31:0] pat_val, exp_c;
	logic [4:0]  gpr_first, gpr_last;
	logic [3:0]  ctl_last;
	logic [4:0]  pair_lo;

	always_comb begin
		pat_val   = pat_r ? crpt_pkg::PAT_B : crpt_pkg::PAT_A;
		exp_c     = pat_val & ctl_mask(ix_r[3:0]);
		gpr_first = RUN_CALLER ? 5'h00 : 5'(crpt_pkg::N_CALLER);
		gpr_last  = RUN_CALLEE ? 5'(N_GPR - 1) : 5'(crpt_pkg::N_CALLER - 1);
		ctl_last  = HAS_FPU ? 4'(crpt_pkg::N_CTRL - 1) : crpt_pkg::CTRL_FLOAT_IX - 4'h1;
		// odd count in a group: last register pairs with itself
		pair_lo   = (ix_r == gpr_last || ix_r == 5'(crpt_pkg::N_CALLER - 1)) ? ix_r : ix_r + 5'h01;
		st_nxt    = st_r;
		ix_nxt    = ix_r;
		pat_nxt   = pat_r;
		first_nxt = first_r;
		busy_nxt  = busy;
		done_nxt  = done;
		fault_nxt = fault;
		gwe_nxt   = 1'b0;
		gre_nxt   = 1'b0;
		cwe_nxt   = 1'b0;
		cre_nxt   = 1'b0;
		gad_nxt   = gpr_addr;
		gwd_nxt   = gpr_wdata;
		csel_nxt  = ctl_sel;
		cwd_nxt   = ctl_wdata;
		case (st_r)
			crpt_pkg::CRPT_IDLE, crpt_pkg::CRPT_DONE: begin
				if (start) begin
					busy_nxt = 1'b1;
					done_nxt = 1'b0;
					pat_nxt  = 1'b0;
					if (RUN_CALLER || RUN_CALLEE) begin
						ix_nxt = gpr_first;
						st_nxt = crpt_pkg::CRPT_WR_A;
					end else begin
						ix_nxt = 5'h00;
						st_nxt = crpt_pkg::CRPT_CWR;
					end
				end
			end
			crpt_pkg::CRPT_WR_A: begin
				gwe_nxt = 1'b1;
				gad_nxt = crpt_pkg::GPR_LIST[ix_r[3:0]];
				gwd_nxt = pat_val;
				st_nxt  = crpt_pkg::CRPT_WR_B;
			end
			crpt_pkg::CRPT_WR_B: begin
				gwe_nxt = 1'b1;
				gad_nxt = crpt_pkg::GPR_LIST[pair_lo[3:0]];
				st_nxt  = crpt_pkg::CRPT_RD_A;
			end
			crpt_pkg::CRPT_RD_A: begin
				gre_nxt = 1'b1;
				gad_nxt = crpt_pkg::GPR_LIST[ix_r[3:0]];
				st_nxt  = crpt_pkg::CRPT_RD_B;
			end
			crpt_pkg::CRPT_RD_B: begin
				gre_nxt   = 1'b1;
				gad_nxt   = crpt_pkg::GPR_LIST[pair_lo[3:0]];
				st_nxt    = crpt_pkg::CRPT_CAP;
			end
			crpt_pkg::CRPT_CAP: begin
				// first register's read data lands now, the second one next cycle
				first_nxt = gpr_rdata;
				st_nxt    = crpt_pkg::CRPT_CHK;
			end
			crpt_pkg::CRPT_CHK: begin
				if (gpr_rdata != first_r || first_r != pat_val) begin
					st_nxt = crpt_pkg::CRPT_FAULT;
				end else if (!pat_r) begin
					pat_nxt = 1'b1;
					st_nxt  = crpt_pkg::CRPT_WR_A;
				end else if (pair_lo != gpr_last) begin
					pat_nxt = 1'b0;
					ix_nxt  = pair_lo + 5'h01;
					st_nxt  = crpt_pkg::CRPT_WR_A;
				end else if (RUN_CONTROL) begin
					pat_nxt = 1'b0;
					ix_nxt  = 5'h00;
					st_nxt  = crpt_pkg::CRPT_CWR;
				end else begin
					st_nxt = crpt_pkg::CRPT_DONE;
				end
			end
			crpt_pkg::CRPT_CWR: begin
				cwe_nxt  = 1'b1;
				csel_nxt = crpt_pkg::CTRL_SEL[ix_r[2:0]];
				cwd_nxt  = exp_c;
				st_nxt   = crpt_pkg::CRPT_CRD;
			end
			crpt_pkg::CRPT_CRD: begin
				cre_nxt = 1'b1;
				st_nxt  = crpt_pkg::CRPT_CWT;
			end
			crpt_pkg::CRPT_CWT: begin
				// read data arrives the cycle after the read strobe
				st_nxt = crpt_pkg::CRPT_CCHK;
			end
			crpt_pkg::CRPT_CCHK: begin
				if ((ctl_rdata & ctl_mask(ix_r[3:0])) != exp_c) begin
					st_nxt = crpt_pkg::CRPT_FAULT;
				end else if (!pat_r) begin
					pat_nxt = 1'b1;
					st_nxt  = crpt_pkg::CRPT_CWR;
				end else if (ix_r[3:0] != ctl_last) begin
					pat_nxt = 1'b0;
					ix_nxt  = ix_r + 5'h01;
					st_nxt  = crpt_pkg::CRPT_CWR;
				end else begin
					st_nxt = crpt_pkg::CRPT_DONE;
				end
			end
			crpt_pkg::CRPT_FAULT: begin
				st_nxt = crpt_pkg::CRPT_FAULT;
			end
			default: st_nxt = crpt_pkg::CRPT_IDLE;
		endcase
		if (st_nxt == crpt_pkg::CRPT_DONE && st_r != crpt_pkg::CRPT_DONE) begin
			done_nxt = 1'b1;
			busy_nxt = 1'b0;
		end
		if (st_nxt == crpt_pkg::CRPT_FAULT) begin
			fault_nxt = 1'b1;
			busy_nxt  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_r      <= crpt_pkg::CRPT_IDLE;
			ix_r      <= 5'h00;
			pat_r     <= 1'b0;
			first_r   <= crpt_pkg::RST_DATA;
			busy      <= 1'b0;
			done      <= 1'b0;
			fault     <= 1'b0;
			gpr_we    <= 1'b0;
			gpr_re    <= 1'b0;
			gpr_addr  <= 4'h0;
			gpr_wdata <= crpt_pkg::RST_DATA;
			ctl_we    <= 1'b0;
			ctl_re    <= 1'b0;
			ctl_sel   <= 3'h0;
			ctl_wdata <= crpt_pkg::RST_DATA;
		end else begin
			st_r      <= st_nxt;
			ix_r      <= ix_nxt;
			pat_r     <= pat_nxt;
			first_r   <= first_nxt;
			busy      <= busy_nxt;
			done      <= done_nxt;
			fault     <= fault_nxt;
			gpr_we    <= gwe_nxt;
			gpr_re    <= gre_nxt;
			gpr_addr  <= gad_nxt;
			gpr_wdata <= gwd_nxt;
			ctl_we    <= cwe_nxt;
			ctl_re    <= cre_nxt;
			ctl_sel   <= csel_nxt;
			ctl_wdata <= cwd_nxt;
		end
	end
endmodule : crpt_sequencer
`default_nettype wire

// *** testbench/crpt_regfile_model.sv ***
// register file model, one-cycle read latency
// bad[0] corrupts reads of register 0xD, bad[1] reads of the float status word
`timescale 1ns/1ns
`default_nettype none
module crpt_regfile_model (
	input wire logic         sys_clk,
	input wire logic [1:0]   bad,
	input wire logic         gpr_we,
	input wire logic         gpr_re,
	input wire logic [3:0]   gpr_addr,
	input wire logic [31:0]  gpr_wdata,
	output logic [31:0]      gpr_rdata,
	input wire logic         ctl_we,
	input wire logic         ctl_re,
	input wire logic [2:0]   ctl_sel,
	input wire logic [31:0]  ctl_wdata,
	output logic [31:0]      ctl_rdata
);
	logic [31:0] g [16];
	logic [31:0] c [8];
	// fixed bits read as zero; idle read bus toggles
	always_ff @(posedge sys_clk) begin
		if (gpr_we) g[gpr_addr] <= gpr_wdata;
		if (ctl_we) c[ctl_sel] <= ctl_wdata & crpt_pkg::CTRL_MASK[ctl_sel];
		gpr_rdata <= gpr_re ? g[gpr_addr] ^ {31'h0, bad[0] && gpr_addr == 4'hD} : ~gpr_rdata;
		ctl_rdata <= ctl_re ? c[ctl_sel] ^ {31'h0, bad[1] && ctl_sel == 3'h7} : ~ctl_rdata;
	end
endmodule : crpt_regfile_model
`default_nettype wire

// *** testbench/crpt_sequencer_assertions.sv ***
// port checker for the register pattern sequencer
// bound to every crpt_sequencer instance
`timescale 1ns/1ns
`default_nettype none
module crpt_sequencer_assertions (
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        start,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        fault,
	input wire logic        gpr_we,
	input wire logic        gpr_re,
	input wire logic [31:0] gpr_wdata,
	input wire logic        ctl_we,
	input wire logic        ctl_re,
	input wire logic [2:0]  ctl_sel,
	input wire logic [31:0] ctl_wdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_rd;
		gpr_we ##1 gpr_re ##1 gpr_re;
	endsequence
	property p_wr_rd; $rose(gpr_we) |=> s_wr_rd; endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("pair write not followed by reads");
	property p_gpr_pat;
		gpr_we |-> gpr_wdata == crpt_pkg::PAT_A || gpr_wdata == crpt_pkg::PAT_B;
	endproperty
	a_gpr_pat: assert property (p_gpr_pat) else $error("bad gpr pattern");
	property p_ctl_pat;
		ctl_we |-> ctl_wdata == (crpt_pkg::PAT_A & crpt_pkg::CTRL_MASK[ctl_sel])
			|| ctl_wdata == (crpt_pkg::PAT_B & crpt_pkg::CTRL_MASK[ctl_sel]);
	endproperty
	a_ctl_pat: assert property (p_ctl_pat) else $error("bad control pattern");
	property p_ctl_rd; ctl_we |=> ctl_re && $stable(ctl_sel); endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control write not read back");
	property p_fault_out; fault |-> !busy && !done && !gpr_we && !ctl_we; endproperty
	a_fault_out: assert property (p_fault_out) else $error("activity after fault");
	property p_fault_hold; fault |=> fault; endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault released");
	property p_done; done |-> !busy && !fault; endproperty
	a_done: assert property (p_done) else $error("done while busy or faulted");
	property p_start; $rose(busy) |-> $past(start) || $past(start, 2); endproperty
	a_start: assert property (p_start) else $error("busy without start");
endmodule : crpt_sequencer_assertions
bind crpt_sequencer crpt_sequencer_assertions u_chk (.*);
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for crpt_sequencer
// the model answers both register ports
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic sys_clk, rst_b, start, busy, done, fault, gpr_we, gpr_re, ctl_we, ctl_re;
	logic [1:0]  bad;
	logic [3:0]  gpr_addr;
	logic [2:0]  ctl_sel;
	logic [31:0] gpr_wdata, gpr_rdata, ctl_wdata, ctl_rdata;
	logic [15:0] seen;
	int          miscompares, checks, n_gw, n_cw;
	logic        nf_busy, nf_done, nf_fault, nf_gwe, nf_gre, nf_cwe, nf_cre;
	logic [3:0]  nf_gad;
	logic [2:0]  nf_csel;
	logic [31:0] nf_gwd, nf_grd, nf_cwd, nf_crd;
	logic [3:0]  wlog [64];
	logic [2:0]  clog [64];
	int          n_nfcw;
	// expected write order: each pair written once per pattern
	localparam logic [3:0] PAIRS [18] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hE, 4'hF, 4'hF,
		4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hD};
	crpt_sequencer uut (.*);
	crpt_regfile_model u_model (.*);
	// variant without float unit, fed by its own healthy model
	crpt_sequencer #(.HAS_FPU(1'b0)) uut_nofpu (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.start     (start),
		.busy      (nf_busy),
		.done      (nf_done),
		.fault     (nf_fault),
		.gpr_we    (nf_gwe),
		.gpr_re    (nf_gre),
		.gpr_addr  (nf_gad),
		.gpr_wdata (nf_gwd),
		.gpr_rdata (nf_grd),
		.ctl_we    (nf_cwe),
		.ctl_re    (nf_cre),
		.ctl_sel   (nf_csel),
		.ctl_wdata (nf_cwd),
		.ctl_rdata (nf_crd)
	);
	crpt_regfile_model u_model_nofpu (
		.sys_clk   (sys_clk),
		.bad       (2'h0),
		.gpr_we    (nf_gwe),
		.gpr_re    (nf_gre),
		.gpr_addr  (nf_gad),
		.gpr_wdata (nf_gwd),
		.gpr_rdata (nf_grd),
		.ctl_we    (nf_cwe),
		.ctl_re    (nf_cre),
		.ctl_sel   (nf_csel),
		.ctl_wdata (nf_cwd),
		.ctl_rdata (nf_crd)
	);
	initial begin
		sys_clk = 0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			n_gw   <= 0;
			n_cw   <= 0;
			n_nfcw <= 0;
			seen   <= 16'h0000;
		end else begin
			if (gpr_we && n_gw < 64) wlog[n_gw] <= gpr_addr;
			if (gpr_we) n_gw <= n_gw + 1;
			if (gpr_we) seen <= seen | (16'h0001 << gpr_addr);
			if (ctl_we && n_cw < 64) clog[n_cw] <= ctl_sel;
			if (ctl_we) n_cw <= n_cw + 1;
			if (nf_cwe) n_nfcw <= n_nfcw + 1;
		end
	end
	task results;
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task reset_dut(input logic [1:0] b);
		rst_b = 0;
		start = 0;
		bad = b;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1;
	endtask : reset_dut
	task kick;
		start = 1;
		@(negedge sys_clk);
		start = 0;
		@(negedge sys_clk);
	endtask : kick
	task wait_end;
		int i;
		for (i = 0; i < 2000 && !done && !fault; i++) @(negedge sys_clk);
		if (i == 2000) begin
			miscompares++;
			results();
		end
	endtask : wait_end
	task t_pass;
		reset_dut(2'h0);
		kick();
		wait_end();
		chk(done, 1);
		chk(fault, 0);
		chk(n_gw, 36);
		chk(seen, 16'hFFFF);
		chk(n_cw, 16);
		for (int k = 0; k < 36; k++) begin
			chk(32'(wlog[k]), 32'(PAIRS[(k / 4) * 2 + k % 2]));
		end
		for (int k = 0; k < 16; k++) begin
			chk(32'(clog[k]), 32'(k / 2));
		end
		chk(nf_done, 1);
		chk(nf_fault, 0);
		chk(n_nfcw, 14);
		kick();
		chk(done, 0);
		chk(busy, 1);
		wait_end();
		chk(done, 1);
	endtask : t_pass
	task t_fault(input logic [1:0] b);
		reset_dut(b);
		kick();
		wait_end();
		chk(fault, 1);
		chk(b[0] ? n_cw : n_gw, b[0] ? 0 : 36);
		kick();
		repeat (4) @(negedge sys_clk);
		chk(fault, 1);
		chk(busy, 0);
	endtask : t_fault
	initial begin
		miscompares = 0;
		checks = 0;
		t_pass();
		t_fault(2'h1);
		t_fault(2'h2);
		results();
	end
endmodule : testbench
`default_nettype wire
